// ===== common/lin_frame_pkg.sv
package lin_frame_pkg;

  // Reserved identifiers for the long writing and reading frames.
  localparam logic [5:0] ID_WRITE_RESERVED = 6'h3c;
  localparam logic [5:0] ID_READ_RESERVED  = 6'h3d;

  // Data byte values with fixed meaning.
  localparam logic [7:0] APP_MARKER        = 8'h80;
  localparam logic [7:0] SLEEP_BYTE        = 8'h00;
  localparam logic [7:0] FILLER_BYTE       = 8'hff;
  localparam logic [6:0] CMD_ID_ASSIGN     = 7'h11;

  // Field positions inside the data bytes.
  localparam int         FLAG_BIT          = 7;
  localparam int         ADDR_MSB          = 6;

  // Frame byte counts.
  localparam logic [3:0] LEN_SHORT         = 4'h2;
  localparam logic [3:0] LEN_LONG          = 4'h8;
  localparam logic [3:0] GP_PARAM_OFFSET   = 4'h2;
  localparam logic [3:0] RES_PARAM_OFFSET  = 4'h3;

  // Dynamic identifier table size and entry widths.
  localparam int         APP_SLOTS         = 4;
  localparam int         ID_W              = 6;
  localparam int         CMD_W             = 7;
  localparam int         PARAM_W           = 64;
  localparam int         LEN_W             = 4;
  localparam int         HW_ADDR_W         = 3;
  localparam int         BUF_W             = CMD_W + PARAM_W + LEN_W;

  // Reset values.
  localparam logic [3:0] COUNT_RESET       = 4'h0;
  localparam logic [6:0] CMD_RESET         = 7'h00;

  typedef enum logic [2:0] {
    K_NONE   = 3'b000,
    K_GP     = 3'b001,
    K_APP_WR = 3'b010,
    K_APP_RD = 3'b011,
    K_RES_WR = 3'b100,
    K_RES_RD = 3'b101,
    K_PREP   = 3'b110
  } kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_PUSH = 2'b10
  } state_t;

endpackage

// ===== core/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end

endmodule

// ===== core/frame_cmd_buffer.sv
module frame_cmd_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot_q [2];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = slot_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (srst) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end else if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// ===== core/lin_slave_frame_decoder.sv
// Summary of operation
// - First application data byte has top bit set.
// - General frame: command byte one, address byte two.
// - Flag one means address match; zero means all.
// - Bound command identifiers execute without address check.
// - Reserved write: marker, command, address, then parameters.
// - Master sends header; one slave answers data.
// - Direct read identifiers trigger only reads.
// - Indirect read answered by node last prepared.
// - Indirect read ignored unless right after preparing.
// - Every answer carries our own node address.
// - Direct read identifiers answered without preparing frame.
// - Reserved read identifier answered only when prepared.
// - Short preparing frame: flagged command, flagged address.
// - Long preparing frame: marker, command, address, filler.
// - Identifier assignment only via reserved write identifier.
// - Own address: four memory bits, three pins.
module lin_slave_frame_decoder (
  input  wire logic                                           clock,
  input  wire logic                                           srst,
  input  wire logic [lin_frame_pkg::HW_ADDR_W-1:0]            hw_addr_pins,
  input  wire logic [3:0]                                     otp_addr_bits,
  input  wire logic                                           otp_addr_mode,
  input  wire logic [lin_frame_pkg::ID_W-1:0]                 gp2_id,
  input  wire logic [lin_frame_pkg::ID_W-1:0]                 gp4_id,
  input  wire logic [lin_frame_pkg::ID_W-1:0]                 prep_id,
  input  wire logic [lin_frame_pkg::APP_SLOTS*lin_frame_pkg::ID_W-1:0]  app_id_table,
  input  wire logic [lin_frame_pkg::APP_SLOTS*lin_frame_pkg::CMD_W-1:0] app_cmd_table,
  input  wire logic [lin_frame_pkg::APP_SLOTS-1:0]            app_valid_mask,
  input  wire logic [lin_frame_pkg::APP_SLOTS-1:0]            app_read_mask,
  input  wire logic                                           frame_start,
  input  wire logic [lin_frame_pkg::ID_W-1:0]                 frame_id,
  input  wire logic                                           rx_valid,
  input  wire logic [7:0]                                     rx_byte,
  input  wire logic                                           frame_end,
  input  wire logic                                           frame_ok,
  output logic                                                frame_ready,
  output logic                                                resp_valid,
  output logic      [lin_frame_pkg::CMD_W-1:0]                resp_cmd,
  output logic      [6:0]                                     resp_node_addr,
  output logic                                                cmd_valid,
  input  wire logic                                           cmd_ready,
  output logic      [lin_frame_pkg::CMD_W-1:0]                cmd_code,
  output logic      [lin_frame_pkg::PARAM_W-1:0]              cmd_params,
  output logic      [lin_frame_pkg::LEN_W-1:0]                cmd_len,
  output logic                                                sleep_req,
  output logic      [6:0]                                     node_addr,
  output logic                                                prep_armed
);

  logic [lin_frame_pkg::HW_ADDR_W-1:0] hw_sync;
  logic [6:0]                          own_addr;
  lin_frame_pkg::state_t               state_q;
  lin_frame_pkg::kind_t                kind_q;
  lin_frame_pkg::kind_t                hit_kind;
  logic [lin_frame_pkg::CMD_W-1:0]     hit_cmd;
  logic [lin_frame_pkg::CMD_W-1:0]     table_cmd_q;
  logic [7:0]                          data_q [8];
  logic [3:0]                          count_q;
  logic                                start_ok;
  logic                                end_ok;
  logic                                prep_armed_q;
  logic [lin_frame_pkg::CMD_W-1:0]     prep_cmd_q;
  logic                                resp_hit;
  logic [lin_frame_pkg::CMD_W-1:0]     resp_cmd_d;
  logic                                resp_valid_q;
  logic [lin_frame_pkg::CMD_W-1:0]     resp_cmd_q;
  logic                                dec_exec;
  logic                                dec_arm;
  logic                                dec_sleep;
  logic [lin_frame_pkg::CMD_W-1:0]     dec_cmd;
  logic [lin_frame_pkg::PARAM_W-1:0]   dec_params;
  logic [lin_frame_pkg::LEN_W-1:0]     dec_len;
  logic [lin_frame_pkg::BUF_W-1:0]     push_data_q;
  logic                                push_ready;
  logic                                sleep_q;
  logic [lin_frame_pkg::BUF_W-1:0]     buf_out;
  logic                                res_filler;

  pin_sync #(
    .WIDTH (lin_frame_pkg::HW_ADDR_W)
  ) u_hw_sync (
    .clock   (clock),
    .srst    (srst),
    .pin_in  (hw_addr_pins),
    .pin_out (hw_sync)
  );

  assign own_addr = otp_addr_mode ?
                    {otp_addr_bits[0], hw_sync[0], hw_sync[1], hw_sync[2], otp_addr_bits[3:1]} :
                    {hw_sync[0], hw_sync[1], hw_sync[2], otp_addr_bits};

  // A new header is held off while a finished command still waits for buffer room.
  assign frame_ready = (state_q != lin_frame_pkg::ST_PUSH);
  assign start_ok    = frame_start && frame_ready;
  assign end_ok      = frame_end && (state_q == lin_frame_pkg::ST_DATA);

  // Identifier classification; reserved identifiers take precedence over the table.
  always_comb begin
    hit_kind = lin_frame_pkg::K_NONE;
    hit_cmd  = lin_frame_pkg::CMD_RESET;
    if (frame_id == lin_frame_pkg::ID_WRITE_RESERVED) begin
      hit_kind = lin_frame_pkg::K_RES_WR;
    end else if (frame_id == lin_frame_pkg::ID_READ_RESERVED) begin
      hit_kind = lin_frame_pkg::K_RES_RD;
    end else if (frame_id == prep_id) begin
      hit_kind = lin_frame_pkg::K_PREP;
    end else if ((frame_id == gp2_id) || (frame_id == gp4_id)) begin
      hit_kind = lin_frame_pkg::K_GP;
    end else begin
      for (int i = 0; i < lin_frame_pkg::APP_SLOTS; i++) begin
        if (app_valid_mask[i] && (app_id_table[i*lin_frame_pkg::ID_W +: lin_frame_pkg::ID_W] == frame_id) &&
            (hit_kind == lin_frame_pkg::K_NONE)) begin
          hit_kind = app_read_mask[i] ? lin_frame_pkg::K_APP_RD : lin_frame_pkg::K_APP_WR;
          hit_cmd  = app_cmd_table[i*lin_frame_pkg::CMD_W +: lin_frame_pkg::CMD_W];
        end
      end
    end
  end

  // Answers are decided at header time, since the slot follows the header at once.
  always_comb begin
    resp_hit   = 1'b0;
    resp_cmd_d = lin_frame_pkg::CMD_RESET;
    if (hit_kind == lin_frame_pkg::K_APP_RD) begin
      resp_hit   = 1'b1;
      resp_cmd_d = hit_cmd;
    end else if ((hit_kind == lin_frame_pkg::K_RES_RD) && prep_armed_q) begin
      resp_hit   = 1'b1;
      resp_cmd_d = prep_cmd_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      resp_valid_q <= 1'b0;
      resp_cmd_q   <= lin_frame_pkg::CMD_RESET;
    end else begin
      resp_valid_q <= start_ok && resp_hit;
      if (start_ok && resp_hit) begin
        resp_cmd_q <= resp_cmd_d;
      end
    end
  end

  assign resp_valid     = resp_valid_q;
  assign resp_cmd       = resp_cmd_q;
  assign resp_node_addr = own_addr;
  assign node_addr      = own_addr;

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q     <= lin_frame_pkg::ST_IDLE;
      kind_q      <= lin_frame_pkg::K_NONE;
      table_cmd_q <= lin_frame_pkg::CMD_RESET;
    end else begin
      case (state_q)
        lin_frame_pkg::ST_IDLE: begin
          if (start_ok) begin
            state_q     <= lin_frame_pkg::ST_DATA;
            kind_q      <= hit_kind;
            table_cmd_q <= hit_cmd;
          end
        end
        lin_frame_pkg::ST_DATA: begin
          if (start_ok) begin
            kind_q      <= hit_kind;
            table_cmd_q <= hit_cmd;
          end else if (end_ok) begin
            state_q <= (frame_ok && dec_exec) ? lin_frame_pkg::ST_PUSH : lin_frame_pkg::ST_IDLE;
          end
        end
        lin_frame_pkg::ST_PUSH: begin
          if (push_ready) begin
            state_q <= lin_frame_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= lin_frame_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bytes past the eighth are dropped; the count saturates at the longest frame.
  always_ff @(posedge clock) begin
    if (srst) begin
      count_q <= lin_frame_pkg::COUNT_RESET;
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= 8'h00;
      end
    end else if (start_ok) begin
      count_q <= lin_frame_pkg::COUNT_RESET;
    end else if (rx_valid && (state_q == lin_frame_pkg::ST_DATA) && (count_q < lin_frame_pkg::LEN_LONG)) begin
      data_q[count_q[2:0]] <= rx_byte;
      count_q              <= count_q + 4'h1;
    end
  end

  always_comb begin
    res_filler = 1'b1;
    for (int i = 3; i < 8; i++) begin
      if (data_q[i] != lin_frame_pkg::FILLER_BYTE) begin
        res_filler = 1'b0;
      end
    end
  end

  // Frame content check at the end of a writing frame.
  always_comb begin
    dec_exec   = 1'b0;
    dec_arm    = 1'b0;
    dec_sleep  = 1'b0;
    dec_cmd    = lin_frame_pkg::CMD_RESET;
    dec_params = '0;
    dec_len    = lin_frame_pkg::COUNT_RESET;
    case (kind_q)
      lin_frame_pkg::K_GP: begin
        dec_cmd    = data_q[0][lin_frame_pkg::ADDR_MSB:0];
        dec_params = {data_q[2], data_q[3], 48'h0};
        dec_len    = (count_q > lin_frame_pkg::GP_PARAM_OFFSET) ? 4'(count_q - lin_frame_pkg::GP_PARAM_OFFSET) : 4'h0;
        dec_exec   = data_q[0][lin_frame_pkg::FLAG_BIT] && (count_q >= lin_frame_pkg::LEN_SHORT) &&
                     (dec_cmd != lin_frame_pkg::CMD_ID_ASSIGN) &&
                     (!data_q[1][lin_frame_pkg::FLAG_BIT] || (data_q[1][lin_frame_pkg::ADDR_MSB:0] == own_addr));
      end
      lin_frame_pkg::K_APP_WR: begin
        dec_cmd    = table_cmd_q;
        dec_params = {data_q[0], data_q[1], data_q[2], data_q[3], data_q[4], data_q[5], data_q[6], data_q[7]};
        dec_len    = count_q;
        dec_exec   = data_q[0][lin_frame_pkg::FLAG_BIT] && (count_q >= lin_frame_pkg::LEN_SHORT) &&
                     (dec_cmd != lin_frame_pkg::CMD_ID_ASSIGN);
      end
      lin_frame_pkg::K_RES_WR: begin
        dec_sleep  = (data_q[0] == lin_frame_pkg::SLEEP_BYTE) && (count_q != lin_frame_pkg::COUNT_RESET);
        dec_cmd    = data_q[1][lin_frame_pkg::ADDR_MSB:0];
        dec_params = {data_q[3], data_q[4], data_q[5], data_q[6], data_q[7], 24'h0};
        dec_len    = (count_q > lin_frame_pkg::RES_PARAM_OFFSET) ? 4'(count_q - lin_frame_pkg::RES_PARAM_OFFSET) : 4'h0;
        if ((data_q[0] == lin_frame_pkg::APP_MARKER) && (count_q == lin_frame_pkg::LEN_LONG)) begin
          if (data_q[1][lin_frame_pkg::FLAG_BIT] && data_q[2][lin_frame_pkg::FLAG_BIT] && res_filler) begin
            dec_arm = (data_q[2][lin_frame_pkg::ADDR_MSB:0] == own_addr);
          end else begin
            dec_exec = !data_q[2][lin_frame_pkg::FLAG_BIT] ||
                       (data_q[2][lin_frame_pkg::ADDR_MSB:0] == own_addr);
          end
        end
      end
      lin_frame_pkg::K_PREP: begin
        dec_cmd = data_q[0][lin_frame_pkg::ADDR_MSB:0];
        dec_arm = (count_q == lin_frame_pkg::LEN_SHORT) && data_q[0][lin_frame_pkg::FLAG_BIT] &&
                  data_q[1][lin_frame_pkg::FLAG_BIT] && (data_q[1][lin_frame_pkg::ADDR_MSB:0] == own_addr);
      end
      default: begin
        dec_exec = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prep_armed_q <= 1'b0;
      prep_cmd_q   <= lin_frame_pkg::CMD_RESET;
    end else if (start_ok) begin
      prep_armed_q <= 1'b0;
    end else if (end_ok) begin
      prep_armed_q <= frame_ok && dec_arm;
      if (frame_ok && dec_arm) begin
        prep_cmd_q <= dec_cmd;
      end
    end
  end

  assign prep_armed = prep_armed_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      push_data_q <= '0;
      sleep_q     <= 1'b0;
    end else begin
      sleep_q <= end_ok && frame_ok && dec_sleep;
      if (end_ok && frame_ok && dec_exec) begin
        push_data_q <= {dec_cmd, dec_params, dec_len};
      end
    end
  end

  assign sleep_req = sleep_q;

  frame_cmd_buffer #(
    .WIDTH (lin_frame_pkg::BUF_W)
  ) u_cmd_buf (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (state_q == lin_frame_pkg::ST_PUSH),
    .in_ready  (push_ready),
    .in_data   (push_data_q),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (buf_out)
  );

  assign cmd_code   = buf_out[lin_frame_pkg::BUF_W-1 -: lin_frame_pkg::CMD_W];
  assign cmd_params = buf_out[lin_frame_pkg::LEN_W +: lin_frame_pkg::PARAM_W];
  assign cmd_len    = buf_out[lin_frame_pkg::LEN_W-1:0];

endmodule

// ===== test/lin_frame_decoder_sva.sv
module lin_frame_decoder_sva (
  input wire logic                               clock,
  input wire logic                               srst,
  input wire logic [lin_frame_pkg::HW_ADDR_W-1:0] hw_addr_pins,
  input wire logic [3:0]                         otp_addr_bits,
  input wire logic                               otp_addr_mode,
  input wire logic                               frame_start,
  input wire logic [lin_frame_pkg::ID_W-1:0]     frame_id,
  input wire logic                               frame_end,
  input wire logic                               frame_ok,
  input wire logic                               frame_ready,
  input wire logic                               resp_valid,
  input wire logic [6:0]                         resp_node_addr,
  input wire logic                               cmd_valid,
  input wire logic                               cmd_ready,
  input wire logic [lin_frame_pkg::CMD_W-1:0]    cmd_code,
  input wire logic [lin_frame_pkg::PARAM_W-1:0]  cmd_params,
  input wire logic [lin_frame_pkg::LEN_W-1:0]    cmd_len,
  input wire logic                               sleep_req,
  input wire logic [6:0]                         node_addr,
  input wire logic                               prep_armed
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  function automatic logic [6:0] addr_of(input logic m, input logic [3:0] pa, input logic [2:0] hw);
    return m ? {pa[0], hw[0], hw[1], hw[2], pa[3:1]} : {hw[0], hw[1], hw[2], pa};
  endfunction

  chk_resp_cause: assert property (resp_valid |-> $past(frame_start) && $past(frame_ready) && !$past(resp_valid))
    else $error("answer pulse without a header one cycle earlier");
  chk_answer_addr: assert property (resp_node_addr == node_addr)
    else $error("answer address differs from own address");
  chk_own_addr: assert property (!$past(srst) && !$past(srst, 2) && !$past(srst, 3)
    && hw_addr_pins == $past(hw_addr_pins) && hw_addr_pins == $past(hw_addr_pins, 2)
    && hw_addr_pins == $past(hw_addr_pins, 3) && $stable(otp_addr_bits) && $stable(otp_addr_mode)
    |-> node_addr == addr_of(otp_addr_mode, otp_addr_bits, hw_addr_pins))
    else $error("own address does not follow pins and memory bits");
  chk_sleep_cause: assert property (sleep_req |-> $past(frame_end) && $past(frame_ok))
    else $error("sleep pulse without a good frame end");
  chk_ready_empty: assert property (!frame_ready && !cmd_valid |=> frame_ready)
    else $error("frame input held off although the command buffer had room");
  chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code)
    && $stable(cmd_params) && $stable(cmd_len))
    else $error("waiting command changed before it was taken");
  chk_arm_clear: assert property (frame_start && frame_ready |=> !prep_armed)
    else $error("selection survived a new frame");
  chk_arm_cause: assert property ($rose(prep_armed) |-> $past(frame_end) && $past(frame_ok))
    else $error("selection set without a good frame end");
  chk_indirect_read: assert property (frame_start && frame_ready
    && frame_id == lin_frame_pkg::ID_READ_RESERVED |=> resp_valid == $past(prep_armed))
    else $error("reserved read answered without matching selection");
endmodule

bind lin_slave_frame_decoder lin_frame_decoder_sva chk (.*);

// ===== test/lin_master_model.sv
module lin_master_model (
  input  wire logic       clock,
  input  wire logic       frame_ready,
  output logic            frame_start,
  output logic      [5:0] frame_id,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            frame_end,
  output logic            frame_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_start = 1'b0;
    frame_id = 6'h00;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    frame_end = 1'b0;
    frame_ok = 1'b0;
  end

  // header then data: the master opens each frame with its identifier and sends the bytes in order.
  task automatic send(input logic [5:0] id, input int n, input logic [63:0] b, input logic ok);
    for (int i = 0; i < 50 && frame_ready !== 1'b1; i++) @(negedge clock);
    frame_start = 1'b1;
    frame_id = id;
    @(negedge clock);
    frame_start = 1'b0;
    frame_id = ~id;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_byte = b[63-8*i -: 8];
      @(negedge clock);
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    frame_end = 1'b1;
    frame_ok = ok;
    @(negedge clock);
    frame_end = 1'b0;
    frame_ok = ~ok;
  endtask
endmodule

// ===== test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, otp_addr_mode, cmd_ready, frame_start, rx_valid, frame_end, frame_ok;
  logic [2:0]  hw_addr_pins;
  logic [3:0]  otp_addr_bits, app_valid_mask, app_read_mask, cmd_len;
  logic [5:0]  gp2_id, gp4_id, prep_id, frame_id;
  logic [23:0] app_id_table;
  logic [27:0] app_cmd_table;
  logic [7:0]  rx_byte;
  logic        frame_ready, resp_valid, cmd_valid, sleep_req, prep_armed;
  logic [6:0]  resp_cmd, resp_node_addr, cmd_code, node_addr, last_rcmd;
  logic [63:0] cmd_params;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_resp = 0;
  int          n_sleep = 0;
  int          r;

  lin_master_model m (.*);
  lin_slave_frame_decoder dut (.*);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    if (resp_valid === 1'b1) begin
      n_resp <= n_resp + 1;
      last_rcmd <= resp_cmd;
    end
    if (sleep_req === 1'b1) n_sleep <= n_sleep + 1;
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic frame(input logic [5:0] id, input int n, input logic [63:0] b, input logic ok = 1'b1);
    m.send(id, n, b, ok);
    repeat (4) @(negedge clock);
  endtask

  task automatic take_cmd(input logic [6:0] code, input logic [3:0] len, input logic [63:0] p);
    logic [63:0] mask;
    mask = {64{1'b1}} << (64 - 8 * len);
    for (int i = 0; i < 20 && cmd_valid !== 1'b1; i++) @(negedge clock);
    chk("cmd_valid", 1, cmd_valid);
    chk("cmd_code", code, cmd_code);
    chk("cmd_len", len, cmd_len);
    chk("cmd_params", p & mask, cmd_params & mask);
    cmd_ready = 1'b1;
    @(negedge clock);
    cmd_ready = 1'b0;
    @(negedge clock);
  endtask

  task automatic expect_read(input int exp_n, input logic [6:0] c);
    frame(lin_frame_pkg::ID_READ_RESERVED, 0, 64'h0);
    chk("answers", exp_n, n_resp - r);
    if (exp_n > 0) chk("resp_cmd", c, last_rcmd);
    r = n_resp;
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1;
    hw_addr_pins = 3'b101;
    otp_addr_bits = 4'h3;
    otp_addr_mode = 1'b0;
    cmd_ready = 1'b0;
    gp2_id = 6'h18;
    gp4_id = 6'h28;
    prep_id = 6'h1a;
    // distinct bindings: each node-specific command gets an identifier of its own.
    app_id_table = {6'h00, 6'h00, 6'h21, 6'h09};
    app_cmd_table = {7'h00, 7'h00, 7'h00, 7'h0c};
    app_valid_mask = 4'b0011;
    app_read_mask = 4'b0010;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    r = n_resp;
    chk("node_addr", 7'h53, node_addr);
    chk("frame_ready", 1, frame_ready);
    frame(gp2_id, 2, 64'h85d3 << 48);
    take_cmd(7'h05, 0, 0);
    frame(gp4_id, 4, 64'h8692_1122 << 32);
    chk("cmd_valid", 0, cmd_valid);
    frame(gp4_id, 4, 64'h8612_1122 << 32);
    take_cmd(7'h06, 2, 64'h1122 << 48);
    frame(gp2_id, 2, 64'h05d3 << 48);
    frame(gp2_id, 2, 64'h85d3 << 48, 1'b0);
    chk("cmd_valid", 0, cmd_valid);
    frame(gp2_id, 2, 64'h91d3 << 48);
    chk("cmd_valid", 0, cmd_valid);
    // Short lengths first: a missing length check would otherwise hide behind the full frame.
    for (int n = 2; n <= 8; n = n * 2) begin
      frame(6'h09, n, 64'h8112_3344_5566_7788);
      take_cmd(7'h0c, n, 64'h8112_3344_5566_7788);
    end
    frame(lin_frame_pkg::ID_WRITE_RESERVED, 8, 64'h808f_d301_0203_0405);
    take_cmd(7'h0f, 5, 64'h0102_0304_05 << 24);
    frame(lin_frame_pkg::ID_WRITE_RESERVED, 8, 64'h8089_1201_0203_0405);
    take_cmd(7'h09, 5, 64'h0102_0304_05 << 24);
    frame(lin_frame_pkg::ID_WRITE_RESERVED, 8, 64'h8089_9201_0203_0405);
    chk("cmd_valid", 0, cmd_valid);
    frame(lin_frame_pkg::ID_WRITE_RESERVED, 8, 64'h00ff_ffff_ffff_ffff);
    chk("sleep", 1, n_sleep);
    frame(prep_id, 2, 64'h83d3 << 48);
    chk("prep_armed", 1, prep_armed);
    expect_read(1, 7'h03);
    chk("prep_armed", 0, prep_armed);
    frame(prep_id, 2, 64'h8392 << 48);
    expect_read(0, 0);
    frame(prep_id, 2, 64'h83d3 << 48);
    frame(gp2_id, 2, 64'h8592 << 48);
    expect_read(0, 0);
    frame(lin_frame_pkg::ID_WRITE_RESERVED, 8, 64'h8082_d3ff_ffff_ffff);
    chk("cmd_valid", 0, cmd_valid);
    expect_read(1, 7'h02);
    frame(6'h21, 0, 64'h0);
    chk("answers", 1, n_resp - r);
    chk("resp_cmd", 0, last_rcmd);
    chk("cmd_valid", 0, cmd_valid);
    chk("resp_node_addr", 7'h53, resp_node_addr);
    r = n_resp;
    frame(gp2_id, 2, 64'h85d3 << 48);
    frame(gp2_id, 2, 64'h87d3 << 48);
    frame(gp2_id, 2, 64'h88d3 << 48);
    chk("frame_ready", 0, frame_ready);
    take_cmd(7'h05, 0, 0);
    take_cmd(7'h07, 0, 0);
    take_cmd(7'h08, 0, 0);
    frame(prep_id, 2, 64'h83d3 << 48);
    srst = 1'b1;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    chk("prep_armed", 0, prep_armed);
    otp_addr_mode = 1'b1;
    app_valid_mask = 4'b0000;
    repeat (5) @(negedge clock);
    chk("node_addr", 7'h69, node_addr);
    frame(6'h09, 2, 64'h8112 << 48);
    chk("cmd_valid", 0, cmd_valid);
    frame(gp2_id, 2, 64'h85e9 << 48);
    take_cmd(7'h05, 0, 0);
    report_and_stop();
  end
endmodule
